// ===== logic/spwm_pkg.sv
package spwm_pkg;

  // Register addresses on the internal special function register bus.
  localparam logic [7:0] SPWM_CONTROL_ADDR = 8'ha9;
  localparam logic [7:0] SPWM_DUTY_ADDR = 8'haa;

  // Values after reset: channel disabled, zero duty.
  localparam logic [7:0] SPWM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SPWM_DUTY_RESET = 8'h00;

  // Field positions inside the control register.
  localparam int SPWM_MODE_MSB = 7;
  localparam int SPWM_MODE_LSB = 6;
  localparam int SPWM_PRESCALE_MSB = 5;
  localparam int SPWM_PRESCALE_LSB = 0;

  // Full-scale counts: the number of prescaled ticks in one period.
  localparam logic [7:0] SPWM_FULL_6BIT = 8'h3f;
  localparam logic [7:0] SPWM_FULL_7BIT = 8'h7f;
  localparam logic [7:0] SPWM_FULL_8BIT = 8'hff;

  // Duty masks per resolution.
  localparam logic [7:0] SPWM_MASK_6BIT = 8'h3f;
  localparam logic [7:0] SPWM_MASK_7BIT = 8'h7f;
  localparam logic [7:0] SPWM_MASK_8BIT = 8'hff;

  // Enable and resolution select encodings.
  typedef enum logic [1:0] {
    SPWM_MODE_OFF = 2'b00,
    SPWM_MODE_6BIT = 2'b01,
    SPWM_MODE_7BIT = 2'b10,
    SPWM_MODE_8BIT = 2'b11
  } spwm_mode_t;

endpackage

// ===== logic/spwm_prescaler.sv
`timescale 1ns/1ns
// Divides the core clock by (factor + 1) into a one-cycle tick enable.
module spwm_prescaler #(
  parameter int FACTOR_WIDTH = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [FACTOR_WIDTH-1:0] factor,
  output logic tick
);
  import spwm_pkg::*;

  // All state of the divider.
  typedef struct packed {
    logic [FACTOR_WIDTH-1:0] count;
  } spwm_div_state_t;

  spwm_div_state_t state_reg;
  spwm_div_state_t state_next;

  // The tick fires on the last cycle of each group of (factor + 1) clocks.
  assign tick = run && (state_reg.count >= factor);

  // Count core clock cycles; a smaller factor written mid-count ends the group at once.
  always_comb begin
    state_next = state_reg;
    if (!run || tick) begin
      state_next.count = '0;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  // Register the divider state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // A tick always restarts the count.
  tick_restart_a: assert property (@(posedge core_clk) disable iff (reset)
    tick |=> state_reg.count == '0)
    else $error("Prescaler did not restart after a tick.");

  // With a steady factor of zero every enabled cycle ticks.
  factor_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    run && factor == '0 |-> tick)
    else $error("Factor zero must tick every cycle.");

  // A stopped divider never ticks.
  stopped_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !run |-> !tick)
    else $error("Stopped prescaler produced a tick.");

  cover_tick_c: cover property (@(posedge core_clk) disable iff (reset) run && factor != '0 && tick);

endmodule // spwm_prescaler

// ===== logic/spwm_top.sv
`timescale 1ns/1ns
// One-channel pulse width modulator behind two special function registers.
module spwm_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic pwm_out
);
  import spwm_pkg::*;

  // All state of the modulator in one place.
  typedef struct packed {
    logic [7:0] pwm_control;
    logic [7:0] pwm_duty_cycle;
    logic [7:0] period_cnt;
    logic out;
    logic [7:0] rdata;
  } spwm_state_t;

  spwm_state_t state_reg;
  spwm_state_t state_next;

  // Decoded view of the control register currently held.
  spwm_mode_t mode_now;
  // Prescaled tick from the divider.
  logic tick;
  // Running flag handed to the divider.
  logic run;

  // Working values for the combinational process.
  spwm_mode_t mode_new;
  logic [7:0] full_new;
  logic [7:0] mask_new;
  logic [7:0] duty_new;

  // Mode field of the control register as it stands now; it gates the divider.
  assign mode_now = spwm_mode_t'(state_reg.pwm_control[SPWM_MODE_MSB:SPWM_MODE_LSB]);
  assign run = (mode_now != SPWM_MODE_OFF);

  // The prescaler sits on the core clock, so period length is only ever a count of crystal cycles.
  spwm_prescaler #(
    .FACTOR_WIDTH(6)
  ) u_prescaler (
    .core_clk(core_clk),
    .reset(reset),
    .run(run),
    .factor(state_reg.pwm_control[SPWM_PRESCALE_MSB:SPWM_PRESCALE_LSB]),
    .tick(tick)
  );

  // Register writes, period counting and the output compare.
  always_comb begin
    state_next = state_reg;
    mode_new = SPWM_MODE_OFF;
    full_new = SPWM_FULL_8BIT;
    mask_new = SPWM_MASK_8BIT;
    duty_new = 8'h00;

    // Register writes land in the same cycle the compare sees them.
    if (sfr_wr && sfr_addr == SPWM_CONTROL_ADDR) begin
      state_next.pwm_control = sfr_wdata;
    end else if (sfr_wr && sfr_addr == SPWM_DUTY_ADDR) begin
      state_next.pwm_duty_cycle = sfr_wdata;
    end

    // Reads return a registered copy one cycle later; other addresses read zero.
    // A read in the same cycle as a write returns the value from before that write.
    if (sfr_rd && sfr_addr == SPWM_CONTROL_ADDR) begin
      state_next.rdata = state_reg.pwm_control;
    end else if (sfr_rd && sfr_addr == SPWM_DUTY_ADDR) begin
      state_next.rdata = state_reg.pwm_duty_cycle;
    end else if (sfr_rd) begin
      state_next.rdata = 8'h00;
    end

    // Resolution picks the full-scale count and how many duty bits count.
    mode_new = spwm_mode_t'(state_next.pwm_control[SPWM_MODE_MSB:SPWM_MODE_LSB]);
    case (mode_new)
      SPWM_MODE_6BIT: begin
        full_new = SPWM_FULL_6BIT;
        mask_new = SPWM_MASK_6BIT;
      end
      SPWM_MODE_7BIT: begin
        full_new = SPWM_FULL_7BIT;
        mask_new = SPWM_MASK_7BIT;
      end
      default: begin
        full_new = SPWM_FULL_8BIT;
        mask_new = SPWM_MASK_8BIT;
      end
    endcase
    // Masking here keeps stray upper duty bits away from the compare.
    duty_new = state_next.pwm_duty_cycle & mask_new;

    // The divider follows the mode held now, while this edge already commits the new mode.
    // Both are looked at so that a disabling write stops the counter at the same edge.
    if (mode_new == SPWM_MODE_OFF || mode_now == SPWM_MODE_OFF) begin
      // Disabled channel holds the counter at zero and the pin low.
      state_next.period_cnt = 8'h00;
    end else if (state_reg.period_cnt >= full_new) begin
      // A resolution drop can leave the count beyond the new scale; restart the period at once
      // rather than wait for the next tick with the output stuck low.
      state_next.period_cnt = 8'h00;
    end else if (tick) begin
      // Wrap after full-1, so one period is exactly full ticks long.
      if (state_reg.period_cnt >= full_new - 8'h01) begin
        state_next.period_cnt = 8'h00;
      end else begin
        state_next.period_cnt = state_reg.period_cnt + 8'h01;
      end
    end

    // The compare runs on the fresh duty value, not on a period-latched copy. That is why a
    // mid-period write may add extra edges, but the period average always sits between
    // the old and the new setting.
    if (mode_new == SPWM_MODE_OFF || mode_now == SPWM_MODE_OFF) begin
      state_next.out = 1'b0;
    end else begin
      state_next.out = (state_next.period_cnt < duty_new);
    end
  end

  // Register the whole modulator state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // Reset leaves the channel off, with zero duty and a cleared read latch.
      state_reg.pwm_control <= SPWM_CONTROL_RESET;
      state_reg.pwm_duty_cycle <= SPWM_DUTY_RESET;
      state_reg.period_cnt <= 8'h00;
      state_reg.out <= 1'b0;
      state_reg.rdata <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Both outputs come straight from flip-flops.
  assign sfr_rdata = state_reg.rdata;
  assign pwm_out = state_reg.out;

  // Disabled channel stays low and its counter stays at zero.
  off_stays_low_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_OFF |-> !pwm_out && state_reg.period_cnt == 8'h00)
    else $error("Disabled modulator is active.");

  // In six-bit mode the counter never reaches 63, even right after a resolution drop.
  six_bit_range_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_6BIT |-> state_reg.period_cnt < 8'h3f)
    else $error("Six-bit counter out of range.");

  // In seven-bit mode the counter wraps from 126 to zero.
  seven_bit_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_7BIT && !sfr_wr && tick && state_reg.period_cnt == 8'h7e
    |=> state_reg.period_cnt == 8'h00)
    else $error("Seven-bit counter did not wrap at 127.");

  // In eight-bit mode the counter steps past 253 to 254 before wrapping.
  eight_bit_step_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_8BIT && !sfr_wr && tick && state_reg.period_cnt == 8'hfd
    |=> state_reg.period_cnt == 8'hfe)
    else $error("Eight-bit counter wrapped early.");

  // A duty write of zero forces the pin low on the very next edge.
  duty_immediate_a: assert property (@(posedge core_clk) disable iff (reset)
    sfr_wr && sfr_addr == SPWM_DUTY_ADDR && sfr_wdata == 8'h00 |=> !pwm_out)
    else $error("Duty write did not take effect at once.");

  // Full duty in eight-bit mode holds the pin high while counting.
  full_duty_high_a: assert property (@(posedge core_clk) disable iff (reset)
    (mode_now == SPWM_MODE_8BIT && state_reg.pwm_duty_cycle == 8'hff && !sfr_wr) [*2] |-> pwm_out)
    else $error("Full duty did not hold the pin high.");

  // Without a tick or a register write the counter does not move.
  no_tick_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    run && !tick && !sfr_wr |=> $stable(state_reg.period_cnt))
    else $error("Counter moved without a tick.");

  // In seven-bit mode the counter never reaches 127.
  seven_bit_range_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_7BIT |-> state_reg.period_cnt < 8'h7f)
    else $error("Seven-bit counter out of range.");

  // In six-bit mode the counter wraps from 62 to zero.
  six_bit_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_6BIT && !sfr_wr && tick && state_reg.period_cnt == 8'h3e
    |=> state_reg.period_cnt == 8'h00)
    else $error("Six-bit counter did not wrap at 63.");

  // In eight-bit mode the counter wraps from 254 to zero.
  eight_bit_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_8BIT && !sfr_wr && tick && state_reg.period_cnt == 8'hfe
    |=> state_reg.period_cnt == 8'h00)
    else $error("Eight-bit counter did not wrap at 255.");

  // A control read returns the value held at the read edge.
  control_readback_a: assert property (@(posedge core_clk) disable iff (reset)
    sfr_rd && sfr_addr == SPWM_CONTROL_ADDR |=> sfr_rdata == $past(state_reg.pwm_control))
    else $error("Control read returned a wrong value.");

  // A duty read returns all eight stored bits.
  duty_readback_a: assert property (@(posedge core_clk) disable iff (reset)
    sfr_rd && sfr_addr == SPWM_DUTY_ADDR |=> sfr_rdata == $past(state_reg.pwm_duty_cycle))
    else $error("Duty read returned a wrong value.");

  // A disabling write drops the pin and clears the counter at the same edge.
  disable_clears_a: assert property (@(posedge core_clk) disable iff (reset)
    sfr_wr && sfr_addr == SPWM_CONTROL_ADDR && sfr_wdata[SPWM_MODE_MSB:SPWM_MODE_LSB] == SPWM_MODE_OFF
    |=> !pwm_out && state_reg.period_cnt == 8'h00)
    else $error("Disabling write left the modulator active.");

  // Covers for the main scenarios: six-bit pulses, a duty change, an eight-bit wrap and a disable.
  cover_six_bit_c: cover property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_6BIT && $rose(pwm_out));
  cover_duty_change_c: cover property (@(posedge core_clk) disable iff (reset)
    run && sfr_wr && sfr_addr == SPWM_DUTY_ADDR ##1 $fell(pwm_out));
  cover_eight_wrap_c: cover property (@(posedge core_clk) disable iff (reset)
    mode_now == SPWM_MODE_8BIT && state_reg.period_cnt == 8'hfe ##1 state_reg.period_cnt == 8'h00);
  cover_disable_c: cover property (@(posedge core_clk) disable iff (reset)
    run && sfr_wr && sfr_addr == SPWM_CONTROL_ADDR && sfr_wdata[SPWM_MODE_MSB:SPWM_MODE_LSB] == SPWM_MODE_OFF);

endmodule // spwm_top

// ===== tb/single_channel_pwm_bench.sv
`timescale 1ns/1ns
// Self-checking bench for the one-channel modulator and its two registers.
module single_channel_pwm_bench;
  import spwm_pkg::*;
  logic core_clk = 1'b0; // 25 MHz core clock.
  logic reset = 1'b1; // Held high for the first 16 cycles.
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic pwm_out;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] lfsr_reg = 8'h49; // Fixed seed so every run repeats.
  int h1;
  int h2;

  // Half period of 20 ns gives the 40 ns core clock.
  always #20 core_clk = ~core_clk;

  spwm_top i_dut (
    .core_clk(core_clk),
    .reset(reset),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata),
    .pwm_out(pwm_out)
  );

  // Maximal-length 8-bit sequence; never reaches zero from a non-zero seed.
  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Ticks in one period for a resolution code; also the duty mask.
  function automatic int full_of(input logic [1:0] m);
    case (m)
      2'b01: return 63;
      2'b10: return 127;
      2'b11: return 255;
      default: return 0;
    endcase
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One register write; the strobe lasts exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  // One register read; the answer is registered and settled a cycle later.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    check(16'(sfr_rdata), 16'(exp));
  endtask

  // Counts high cycles over a fixed window; any window one period long sees the same total.
  task automatic count_high(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (pwm_out === 1'b1) h++;
    end
  endtask

  // Programs one mode, reads both registers back and checks the high time of two periods.
  task automatic run_mode(input logic [1:0] m, input logic [5:0] f, input logic [7:0] d);
    int p;
    int h;
    int t;
    p = full_of(m) * (int'(f) + 1);
    wr(SPWM_DUTY_ADDR, d);
    wr(SPWM_CONTROL_ADDR, {m, f});
    rd(SPWM_CONTROL_ADDR, {m, f});
    rd(SPWM_DUTY_ADDR, d);
    count_high(p, h);
    count_high(p, h);
    check(16'(h), 16'((int'(d) & full_of(m)) * (int'(f) + 1)));
    // The next period is counted in two parts, so a cycle lost or doubled between the two windows would show in the total.
    count_high(p - 1, h);
    count_high(1, t);
    check(16'(h + t), 16'((int'(d) & full_of(m)) * (int'(f) + 1)));
  endtask

  // Main sequence: reset, register map, every mode, immediate duty change, disable.
  initial begin
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    rd(SPWM_CONTROL_ADDR, SPWM_CONTROL_RESET);
    rd(SPWM_DUTY_ADDR, SPWM_DUTY_RESET);
    wr(8'ha8, 8'h55);
    rd(8'ha8, 8'h00);
    wr(SPWM_DUTY_ADDR, 8'h20);
    count_high(300, h1);
    check(16'(h1), 16'h0000);
    run_mode(2'b01, 6'h3f, 8'hff);
    run_mode(2'b10, 6'h00, 8'h80);
    for (int m = 1; m < 4; m++) begin
      lfsr_reg = lfsr_step(lfsr_reg);
      h2 = int'(lfsr_reg[2:0]);
      lfsr_reg = lfsr_step(lfsr_reg);
      run_mode(2'(m), 6'(h2), lfsr_reg);
    end
    repeat (3) begin
      lfsr_reg = lfsr_step(lfsr_reg);
      h2 = int'(lfsr_reg[1:0]);
      lfsr_reg = lfsr_step(lfsr_reg);
      run_mode((h2 == 0) ? 2'b11 : 2'(h2), 6'(lfsr_reg[6:4]), lfsr_step(lfsr_reg));
    end
    run_mode(2'b11, 6'h00, 8'h00);
    wr(SPWM_DUTY_ADDR, 8'hff);
    @(negedge core_clk);
    check(16'(pwm_out), 16'h0001);
    wr(SPWM_DUTY_ADDR, 8'h40);
    count_high(255, h1);
    count_high(100, h1);
    wr(SPWM_DUTY_ADDR, 8'hc0);
    count_high(153, h2);
    // Two cycles of the write go uncounted, so the counted total can only sit below the period total.
    check(16'(h1 + h2 >= 64 && h1 + h2 <= 192), 16'h0001);
    wr(SPWM_CONTROL_ADDR, 8'h05);
    count_high(400, h1);
    check(16'(h1), 16'h0000);
    conclude();
  end
endmodule // single_channel_pwm_bench
